// ### strap_defines.svh
// constants for the strap sampling and pin configuration block
// assumes: single 10 MHz clock domain, synchronous active-high reset
// Function
// - upper base strap low alone selects core base
// - both base straps low enter xor-tree test
// - float strap low floats all outputs except analog
// - jtag straps sampled at reset, internally pulled up
// - primary jtag strap low routes jtag group one
// - keyscan strap low routes jtag group two; both illegal
// - boot memory strap low enables shared boot memory
// - xor-tree chains all pins onto xor output
// - function pulls enabled automatically when routed
// - programmable pulls need input direction, main-well enable
// - non-programmable jtag pulls always active
// - host general pin pulls default to pull-up
// - other programmable pulls default to floating
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

`define NUM_PORT_PINS   8
`define NUM_HOST_PINS   8
`define NUM_XOR_PINS    16
`define NUM_FUNC_PINS   4
`define BASE_FIXED      2'h3
`define BASE_ALT_LOW    2'h2
`define BASE_CORE       2'h1
`define BASE_XOR        2'h0
`define STRAP_PULLUP    1'h1
`define PULL_OFF        1'h0
`define PULL_ON         1'h1
`define PULL_SEL_UP     1'h1
`define DIR_INPUT       1'h0
`define WELL_ON         1'h1
`define HOST_PULL_RST   8'hff
`define PORT_PULL_RST   8'h00

`endif

// ### strap_pkg.sv
// types for the strap sampling block
// assumes: included constants header alongside
package strap_pkg;
    typedef enum logic [1:0] {
        base_fixed,
        base_alt_low,
        base_core,
        base_xor_test
    } base_mode_t;
endpackage

// ### pull_ctrl.sv
// per-pin pull resistor control for programmable pulls; automatic function pulls are decoded outside this module
// assumes: pull bits come from port configuration logic on the same clock
`timescale 1ns/1ps
`include "strap_defines.svh"
module pull_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [`NUM_PORT_PINS-1:0] port_direction_bit,
    input  wire logic [`NUM_PORT_PINS-1:0] port_main_well_enable,
    input  wire logic [`NUM_PORT_PINS-1:0] pin_on_main_well,
    input  wire logic [`NUM_PORT_PINS-1:0] port_pull_enable,
    input  wire logic [`NUM_PORT_PINS-1:0] port_pull_select,
    input  wire logic [`NUM_PORT_PINS-1:0] pull_wr,
    input  wire logic [`NUM_PORT_PINS-1:0] pull_reset_value,
    output logic      [`NUM_PORT_PINS-1:0] pull_up_on,
    output logic      [`NUM_PORT_PINS-1:0] pull_down_on
);
    logic [`NUM_PORT_PINS-1:0] en_ff;
    logic [`NUM_PORT_PINS-1:0] sel_ff;
    logic [`NUM_PORT_PINS-1:0] allow;

    genvar i;
    generate
        for (i = 0; i < `NUM_PORT_PINS; i++) begin : g_pin
            always_ff @(posedge clk) begin
                if (rst) begin
                    // reset value: pull-up or float per pin group
                    en_ff[i]  <= pull_reset_value[i];
                    sel_ff[i] <= `PULL_SEL_UP;
                end else if (pull_wr[i]) begin
                    en_ff[i]  <= port_pull_enable[i];
                    sel_ff[i] <= port_pull_select[i];
                end
            end
            // only an input pin, and a powered main-well pin, gets a pull
            assign allow[i] = (port_direction_bit[i] == `DIR_INPUT) &&
                (!pin_on_main_well[i] ||
                 port_main_well_enable[i] == `WELL_ON);
            assign pull_up_on[i]   = allow[i] & en_ff[i] & sel_ff[i];
            assign pull_down_on[i] = allow[i] & en_ff[i] & ~sel_ff[i];
        end
    endgenerate

    a_pull_needs_input: assert property (
        @(posedge clk) disable iff (rst)
        (pull_up_on[0] | pull_down_on[0]) |->
        port_direction_bit[0] == `DIR_INPUT)
        else $error("pull active on output pin");
endmodule

// ### strap_config.sv
// strap capture, pin routing, float control, xor-tree and pull control
// assumes: strap pins asynchronous, synchronised here; rst covers power-up
// and the external standby reset input
`timescale 1ns/1ps
`include "strap_defines.svh"
module strap_config (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [1:0]                base_address_straps,
    input  wire logic                      float_all_strap,
    input  wire logic                      jtag_primary_strap,
    input  wire logic                      jtag_keyscan_strap,
    input  wire logic                      shared_boot_memory_strap,
    input  wire logic [`NUM_XOR_PINS-1:0]  xor_pins_in,
    input  wire logic [`NUM_PORT_PINS-1:0] port_direction_bit,
    input  wire logic [`NUM_PORT_PINS-1:0] port_main_well_enable,
    input  wire logic [`NUM_PORT_PINS-1:0] pin_on_main_well,
    input  wire logic [`NUM_PORT_PINS-1:0] port_pull_enable,
    input  wire logic [`NUM_PORT_PINS-1:0] port_pull_select,
    input  wire logic [`NUM_PORT_PINS-1:0] port_pull_wr,
    input  wire logic [`NUM_PORT_PINS-1:0] port_is_host,
    input  wire logic [`NUM_FUNC_PINS-1:0] func_routed,
    input  wire logic [`NUM_FUNC_PINS-1:0] func_pull_up,
    output logic                           straps_valid,
    output strap_pkg::base_mode_t          base_mode,
    output logic                           xor_test_mode,
    output logic                           xor_tree_out,
    output logic                           outputs_float,
    output logic                           jtag_on_group1,
    output logic                           jtag_on_group2,
    output logic                           jtag_strap_illegal,
    output logic                           shared_boot_enable,
    output logic [`NUM_PORT_PINS-1:0]      pull_up_on,
    output logic [`NUM_PORT_PINS-1:0]      pull_down_on,
    output logic [`NUM_FUNC_PINS-1:0]      func_pull_up_on,
    output logic [`NUM_FUNC_PINS-1:0]      func_pull_down_on,
    output logic                           jtag_fixed_pull_up,
    output logic                           jtag_fixed_pull_down
);
    // ========================================================
    // synchronisers
    logic [5:0] s1_ff;
    logic [5:0] s2_ff;
    logic [`NUM_XOR_PINS-1:0] x1_ff;
    logic [`NUM_XOR_PINS-1:0] x2_ff;

    // constant reset value mirrors the internal pull-ups on the straps
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= {6{`STRAP_PULLUP}};
            s2_ff <= {6{`STRAP_PULLUP}};
        end else begin
            s1_ff <= {base_address_straps, float_all_strap,
                      jtag_primary_strap, jtag_keyscan_strap,
                      shared_boot_memory_strap};
            s2_ff <= s1_ff;
        end
    end

    always_ff @(posedge clk) begin
        x1_ff <= xor_pins_in;
        x2_ff <= x1_ff;
    end

    // ========================================================
    // capture: the second edge after release has settled samples
    logic [1:0] settle_ff;
    logic       valid_ff;
    logic [1:0] base_ff;
    logic       float_ff;
    logic       jp_ff;
    logic       jk_ff;
    logic       boot_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            settle_ff <= 2'h0;
            valid_ff  <= 1'h0;
        end else begin
            settle_ff <= {settle_ff[0], 1'h1};
            if (settle_ff[1]) begin
                valid_ff <= 1'h1;
            end
        end
    end

    // straps are taken once after release, then frozen until reset
    always_ff @(posedge clk) begin
        if (rst) begin
            base_ff  <= `BASE_FIXED;
            float_ff <= `STRAP_PULLUP;
            jp_ff    <= `STRAP_PULLUP;
            jk_ff    <= `STRAP_PULLUP;
            boot_ff  <= `STRAP_PULLUP;
        end else if (settle_ff[1] && !valid_ff) begin
            base_ff  <= s2_ff[5:4];
            float_ff <= s2_ff[3];
            jp_ff    <= s2_ff[2];
            jk_ff    <= s2_ff[1];
            boot_ff  <= s2_ff[0];
        end
    end

    assign straps_valid = valid_ff;

    // ========================================================
    // decode
    always_comb begin
        unique case (base_ff)
            `BASE_FIXED:   base_mode = strap_pkg::base_fixed;
            `BASE_ALT_LOW: base_mode = strap_pkg::base_alt_low;
            `BASE_CORE:    base_mode = strap_pkg::base_core;
            `BASE_XOR:     base_mode = strap_pkg::base_xor_test;
        endcase
    end

    assign xor_test_mode = valid_ff && base_ff == `BASE_XOR;
    // the board must not combine float with xor-tree; xor mode is not gated by float
    assign outputs_float = valid_ff && !float_ff;
    // illegal combination drives neither group as jtag
    assign jtag_on_group1 = !jp_ff && jk_ff;
    assign jtag_on_group2 = jp_ff && !jk_ff;
    assign jtag_strap_illegal = valid_ff && !jp_ff && !jk_ff;
    assign shared_boot_enable = !boot_ff;

    // ========================================================
    // xor tree: registered so the test pin is glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            xor_tree_out <= 1'h0;
        end else begin
            xor_tree_out <= xor_test_mode ? ^x2_ff : 1'h0;
        end
    end

    // ========================================================
    // pulls
    assign func_pull_up_on   = func_routed & func_pull_up;
    assign func_pull_down_on = func_routed & ~func_pull_up;
    assign jtag_fixed_pull_up   = `PULL_ON;
    assign jtag_fixed_pull_down = `PULL_ON;

    logic [`NUM_PORT_PINS-1:0] pull_rst_val;
    assign pull_rst_val = (port_is_host & `HOST_PULL_RST) |
                          (~port_is_host & `PORT_PULL_RST);

    pull_ctrl u_pull (
        .clk                   (clk),
        .rst                   (rst),
        .port_direction_bit    (port_direction_bit),
        .port_main_well_enable (port_main_well_enable),
        .pin_on_main_well      (pin_on_main_well),
        .port_pull_enable      (port_pull_enable),
        .port_pull_select      (port_pull_select),
        .pull_wr               (port_pull_wr),
        .pull_reset_value      (pull_rst_val),
        .pull_up_on            (pull_up_on),
        .pull_down_on          (pull_down_on)
    );

    // ========================================================
    // checks
    // capture is seen one edge after the load condition, hence |=> below
    a_straps_held: assert property (
        @(posedge clk) disable iff (rst)
        valid_ff && $past(valid_ff) |-> $stable(base_ff) && $stable(float_ff))
        else $error("strap changed after capture");
    a_capture_load: assert property (
        @(posedge clk) disable iff (rst)
        settle_ff[1] && !valid_ff |=>
        {base_ff, float_ff, jp_ff, jk_ff, boot_ff} == $past(s2_ff))
        else $error("latched straps differ from synchronised pins");
    a_valid_kept: assert property (
        @(posedge clk) disable iff (rst)
        valid_ff |=> valid_ff)
        else $error("straps valid dropped without reset");
    a_xor_mode_map: assert property (
        @(posedge clk) disable iff (rst)
        xor_test_mode |-> base_mode == strap_pkg::base_xor_test)
        else $error("xor mode without both base straps low");
    a_core_base: assert property (
        @(posedge clk) disable iff (rst)
        valid_ff && base_ff == `BASE_CORE |->
        base_mode == strap_pkg::base_core)
        else $error("core base not selected");
    a_float_map: assert property (
        @(posedge clk) disable iff (rst)
        outputs_float |-> !float_ff)
        else $error("float without strap low");
    a_float_after_valid: assert property (
        @(posedge clk) disable iff (rst)
        !valid_ff |-> !outputs_float && !xor_test_mode)
        else $error("float or xor mode before capture");
    a_jtag_exclusive: assert property (
        @(posedge clk) disable iff (rst)
        !(jtag_on_group1 && jtag_on_group2))
        else $error("jtag on both groups");
    a_jtag_group1: assert property (
        @(posedge clk) disable iff (rst)
        jtag_on_group1 |-> !jp_ff)
        else $error("group one jtag without strap");
    a_jtag_group2: assert property (
        @(posedge clk) disable iff (rst)
        jtag_on_group2 |-> !jk_ff && jp_ff)
        else $error("group two jtag without keyscan strap alone");
    a_jtag_illegal: assert property (
        @(posedge clk) disable iff (rst)
        valid_ff && !jp_ff && !jk_ff |-> jtag_strap_illegal && !jtag_on_group1)
        else $error("illegal jtag straps not flagged");
    a_boot_enable: assert property (
        @(posedge clk) disable iff (rst)
        shared_boot_enable |-> boot_ff == 1'h0)
        else $error("boot memory enabled with strap high");
    a_boot_default: assert property (
        @(posedge clk) disable iff (rst)
        boot_ff |-> !shared_boot_enable)
        else $error("boot memory enabled with strap at pull-up");
    // release is seen at edge 1, straps_valid is visible from edge 4
    a_capture_time: assert property (
        @(posedge clk)
        $fell(rst) |-> ##3 straps_valid)
        else $error("straps not valid three edges after release");
    a_xor_out_off: assert property (
        @(posedge clk) disable iff (rst)
        !$past(xor_test_mode) |-> !xor_tree_out)
        else $error("xor output outside test mode");
    a_xor_tree_value: assert property (
        @(posedge clk) disable iff (rst)
        $past(xor_test_mode) |-> xor_tree_out == ^$past(x2_ff))
        else $error("xor output not the parity of the pins");
    a_func_pull_routed: assert property (
        @(posedge clk) disable iff (rst)
        (func_pull_up_on | func_pull_down_on) == func_routed)
        else $error("function pull not following routing");
    // pins other than host pins must come out of reset floating
    a_pull_reset_state: assert property (
        @(posedge clk) disable iff (rst)
        $fell(rst) |->
        (pull_up_on & ~pull_rst_val) == 8'h00 && pull_down_on == 8'h00)
        else $error("pull active after reset outside host pins");
endmodule

// ### strap_board.sv
// board model: external strap pull-downs behind internal pull-ups
// assumes: fit bits change around a reset of the device and again after capture
`timescale 1ns/1ps
module strap_board (
    input  wire logic [5:0] fit,
    input  wire logic       allow_bad,
    output logic      [5:0] pins
);
    logic [5:0] f;
    // ==========================================================
    // fit order {base1, base0, float, jtag_p, jtag_k, boot}
    always_comb begin
        f = fit;
        // both base pull-downs fitted select xor-tree: float strap left open
        if (f[5:4] == 2'h3) f[3] = 1'h0;
        // both jtag straps low only when a fault is commanded
        if (!allow_bad && f[2] && f[1]) f[1] = 1'h0;
        pins = ~f;
    end
endmodule

// ### strap_config_bench.sv
// self-checking bench for strap capture, pin routing and pulls
// assumes: strap_board drives the strap pins, 10 MHz clock
`timescale 1ns/1ps
module strap_config_bench;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        probe = 1'h0;
    logic        allow_bad = 1'h0;
    logic [5:0]  fit = 6'h00;
    logic [5:0]  sp, cap;
    logic [15:0] xp = 16'h0000;
    logic [7:0]  dir = 8'h00, mwe = 8'hff, mow = 8'h00, host = 8'h00;
    logic [7:0]  en = 8'h00, sel = 8'h00, wr = 8'h00, pe, ps, pu, pd;
    logic [3:0]  fr = 4'h0, fp = 4'h0, fu, fd;
    logic        sv, xm, xo, of, g1, g2, il, sb, ju, jd;
    logic [35:0] obs, ex;
    logic [35:0] q[$];
    logic [31:0] r = 32'hf21999be;
    int          mismatches = 0, compares = 0, cyc = 0;
    strap_pkg::base_mode_t bm;

    always #50 clk = ~clk;
    assign obs = {sv, bm, xm, of, g1, g2, il, sb, pu, pd, fu, fd, ju, jd, xo};

    strap_board board (.fit(fit), .allow_bad(allow_bad), .pins(sp));

    strap_config DUT (
        .clk(clk), .rst(rst), .base_address_straps(sp[5:4]),
        .float_all_strap(sp[3]), .jtag_primary_strap(sp[2]),
        .jtag_keyscan_strap(sp[1]), .shared_boot_memory_strap(sp[0]),
        .xor_pins_in(xp), .port_direction_bit(dir),
        .port_main_well_enable(mwe), .pin_on_main_well(mow),
        .port_pull_enable(en), .port_pull_select(sel),
        .port_pull_wr(wr), .port_is_host(host), .func_routed(fr),
        .func_pull_up(fp), .straps_valid(sv), .base_mode(bm),
        .xor_test_mode(xm), .xor_tree_out(xo), .outputs_float(of),
        .jtag_on_group1(g1), .jtag_on_group2(g2),
        .jtag_strap_illegal(il), .shared_boot_enable(sb),
        .pull_up_on(pu), .pull_down_on(pd), .func_pull_up_on(fu),
        .func_pull_down_on(fd), .jtag_fixed_pull_up(ju),
        .jtag_fixed_pull_down(jd));

    // ==========================================================
    // expected outputs from strap levels and pull settings
    function automatic logic [35:0] expv(input logic [5:0] s);
        logic [7:0] g;
        logic       x3;
        g = ~dir & (~mow | mwe);
        x3 = (s[5:4] == 2'h0);
        return {1'h1, 2'h3 - s[5:4], x3, ~s[3], ~s[2] & s[1],
                s[2] & ~s[1], ~s[2] & ~s[1], ~s[0], pe & ps & g,
                pe & ~ps & g, fr & fp, fr & ~fp, 2'h3, x3 & ^xp};
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic note(input logic [5:0] s);
        q.push_back(expv(s));
        probe <= 1'h1;
        @(posedge clk);
        probe <= 1'h0;
        @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // monitor: oldest note against the outputs shown
    always @(posedge clk) begin
        if (probe && q.size() > 0) begin
            ex = q.pop_front();
            compares++;
            if (obs !== ex) begin
                mismatches++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, obs, ex);
            end
        end
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ==========================================================
    // driver: all 64 board fit settings, then hold, xor and pulls
    initial begin
        repeat (10) @(posedge clk);
        for (int i = 0; i < 64; i++) begin
            r = lfsr(r);
            fit <= i[5:0];
            allow_bad <= r[0];
            {host, dir, mwe, mow} <= r;
            {fr, fp} <= r[13:6];
            xp <= 16'h0000;
            rst <= 1'h1;
            repeat (2) @(posedge clk);
            rst <= 1'h0;
            for (int n = 0; n < 8 && sv !== 1'h1; n++) @(posedge clk);
            pe = host;
            ps = host;
            cap = sp;
            note(cap);
            r = lfsr(r);
            fit <= r[5:0];
            xp <= r[21:6];
            repeat (4) @(posedge clk);
            note(cap);
            r = lfsr(r);
            {en, sel, wr, dir} <= r;
            {mwe, mow} <= {r[7:0] ^ r[31:24], r[15:8] ^ r[23:16]};
            {fr, fp} <= r[27:20];
            @(posedge clk);
            wr <= 8'h00;
            pe = (pe & ~wr) | (en & wr);
            ps = (ps & ~wr) | (sel & wr);
            note(cap);
        end
        print_verdict();
    end
endmodule
